//--- inc/citc_pkg.sv
// constants for the charge indicator and die thermal controller
package citc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_POWER_STATUS = 8'h01;
    localparam logic [7:0] ADDR_IND_DET_CTRL = 8'h32;
    localparam logic [7:0] ADDR_CHG_TIMER_IND_CFG = 8'h34;
    localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h35;
    localparam logic [7:0] ADDR_IRQ_ENABLE_BANK = 8'h43;
    localparam logic [7:0] ADDR_SHUTDOWN_CTRL = 8'h8F;
    // field positions
    localparam int STAT_OVERTEMP_BIT = 7;
    localparam int STAT_PRESENT_BIT = 5;
    localparam int STAT_SAFE_MODE_BIT = 3;
    localparam int DET_EN_BIT = 6;
    localparam int MAN_PAT_LSB = 4;
    localparam int IND_SRC_BIT = 3;
    localparam int PRE_TIMER_LSB = 6;
    localparam int IND_MODE_BIT = 4;
    localparam int FAST_TIMER_LSB = 0;
    localparam int STOP_ON_HOT_BIT = 3;
    localparam int OT_IRQ_EN_BIT = 7;
    localparam int SD_ON_L3_BIT = 2;
    // reset values
    localparam logic DET_EN_RST = 1'h1;
    localparam logic [1:0] MAN_PAT_RST = 2'h0;
    localparam logic IND_SRC_RST = 1'h0;
    localparam logic [1:0] PRE_TIMER_RST = 2'h1;
    localparam logic IND_MODE_RST = 1'h0;
    localparam logic [1:0] FAST_TIMER_RST = 2'h1;
    localparam logic STOP_ON_HOT_RST = 1'h0;
    localparam logic OT_IRQ_EN_RST = 1'h0;
    localparam logic SD_ON_L3_RST = 1'h0;
    // manual pattern codes
    localparam logic [1:0] MAN_HIZ = 2'h0;
    localparam logic [1:0] MAN_HALF_HZ = 2'h1;
    localparam logic [1:0] MAN_TWO_HZ = 2'h2;
    localparam logic [1:0] MAN_LOW = 2'h3;
    // timing: one blink tick is 1/16 s
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 62500;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int TICKS_PER_S = 16;
    localparam int PROBE_S = 16;
    localparam int PROBE_TICKS = PROBE_S * TICKS_PER_S;
    localparam int NUM_LEVELS = 3;
    // indicator patterns
    typedef enum logic [2:0] {
        PAT_HIZ,
        PAT_LOW,
        PAT_HALF_HZ,
        PAT_ONE_HZ,
        PAT_TWO_HZ,
        PAT_FOUR_HZ
    } citc_pat_t;
endpackage

//--- verilog/citc_top.sv
// charge indicator, battery presence and die thermal warning logic
`timescale 1ns/1ps
module citc_top
    import citc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // charger and supply status
    input wire logic INPUT_PRESENT,
    input wire logic INPUT_SUFFICIENT,
    input wire logic CHARGING,
    input wire logic BATT_FULL,
    input wire logic VBUS_OVER_6V3,
    input wire logic CHG_TIMER_EXPIRED,
    input wire logic BATT_NEAR_TARGET,
    // battery sense comparator, high above 2.2 V
    input wire logic BATTERY_SENSE_VOLTAGE_HI,
    // die temperature comparators per level
    input wire logic [2:0] DIE_ABOVE_LEVEL,
    input wire logic [2:0] DIE_BELOW_HYST,
    // indicator pin, open drain
    input wire logic CHARGE_INDICATOR_PIN_IN,
    output logic CHARGE_INDICATOR_PIN_OUT,
    output logic CHARGE_INDICATOR_PIN_OE,
    // charger control and events
    output logic CHG_MIN_CURRENT,
    output logic CHG_STOP,
    output logic CHG_SAFE_MODE,
    output logic SHUTDOWN_REQ,
    output logic BATT_PROBE,
    output logic BATT_PRESENT_IRQ,
    output logic DIE_OVERTEMP_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic det_en;
    logic [1:0] man_pat;
    logic ind_src;
    logic [1:0] pre_timer;
    logic ind_mode;
    logic [1:0] fast_timer;
    logic stop_on_hot;
    logic ot_irq_en;
    logic sd_on_l3;
    logic present;
    logic safe_mode;
    logic [NUM_LEVELS-1:0] lvl;
    citc_pat_t pat;
    logic [22:0] presc;
    logic [4:0] phase;
    logic [7:0] probe_cnt;

    wire wr_det = WR && (ADDR == ADDR_IND_DET_CTRL);
    wire wr_cfg = WR && (ADDR == ADDR_CHG_TIMER_IND_CFG);
    wire wr_lim = WR && (ADDR == ADDR_CURRENT_LIMIT);
    wire wr_irq = WR && (ADDR == ADDR_IRQ_ENABLE_BANK);
    wire wr_sd = WR && (ADDR == ADDR_SHUTDOWN_CTRL);

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            det_en <= DET_EN_RST;
            man_pat <= MAN_PAT_RST;
            ind_src <= IND_SRC_RST;
            pre_timer <= PRE_TIMER_RST;
            ind_mode <= IND_MODE_RST;
            fast_timer <= FAST_TIMER_RST;
            stop_on_hot <= STOP_ON_HOT_RST;
            ot_irq_en <= OT_IRQ_EN_RST;
            sd_on_l3 <= SD_ON_L3_RST;
        end
        else
        begin
            if (wr_det)
            begin
                det_en <= WDATA[DET_EN_BIT];
                man_pat <= WDATA[MAN_PAT_LSB +: 2];
                ind_src <= WDATA[IND_SRC_BIT];
            end
            if (wr_cfg)
            begin
                pre_timer <= WDATA[PRE_TIMER_LSB +: 2];
                ind_mode <= WDATA[IND_MODE_BIT];
                fast_timer <= WDATA[FAST_TIMER_LSB +: 2];
            end
            if (wr_lim)
                stop_on_hot <= WDATA[STOP_ON_HOT_BIT];
            if (wr_irq)
                ot_irq_en <= WDATA[OT_IRQ_EN_BIT];
            if (wr_sd)
                sd_on_l3 <= WDATA[SD_ON_L3_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, unmapped reads give zero
    logic [7:0] stat_word;
    logic [7:0] det_word;
    logic [7:0] cfg_word;
    logic [7:0] next_rdata;

    always_comb
    begin
        stat_word = 8'h00;
        stat_word[STAT_OVERTEMP_BIT] = lvl[1];
        stat_word[STAT_PRESENT_BIT] = present;
        stat_word[STAT_SAFE_MODE_BIT] = safe_mode;
        det_word = 8'h00;
        det_word[DET_EN_BIT] = det_en;
        det_word[MAN_PAT_LSB +: 2] = man_pat;
        det_word[IND_SRC_BIT] = ind_src;
        cfg_word = 8'h00;
        cfg_word[PRE_TIMER_LSB +: 2] = pre_timer;
        cfg_word[IND_MODE_BIT] = ind_mode;
        cfg_word[FAST_TIMER_LSB +: 2] = fast_timer;
        next_rdata = 8'h00;
        if (ADDR == ADDR_POWER_STATUS)
            next_rdata = stat_word;
        else if (ADDR == ADDR_IND_DET_CTRL)
            next_rdata = det_word;
        else if (ADDR == ADDR_CHG_TIMER_IND_CFG)
            next_rdata = cfg_word;
        else if (ADDR == ADDR_CURRENT_LIMIT)
            next_rdata[STOP_ON_HOT_BIT] = stop_on_hot;
        else if (ADDR == ADDR_IRQ_ENABLE_BANK)
            next_rdata[OT_IRQ_EN_BIT] = ot_irq_en;
        else if (ADDR == ADDR_SHUTDOWN_CTRL)
            next_rdata[SD_ON_L3_BIT] = sd_on_l3;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            RDATA <= 8'h00;
        else if (RD)
            RDATA <= next_rdata;
        else
            RDATA <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // die thermal warning levels, set on entry, clear below hysteresis
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LEVELS; gi++)
        begin : g_level
            always_ff @(posedge SYS_CLK or negedge ARST_N)
            begin
                if (!ARST_N)
                    lvl[gi] <= 1'b0;
                else if (DIE_ABOVE_LEVEL[gi])
                    lvl[gi] <= 1'b1;
                else if (DIE_BELOW_HYST[gi])
                    lvl[gi] <= 1'b0;
            end
        end
    endgenerate

    // level one and above limit current; stop bit turns that into a halt
    wire next_min_cur = lvl[0] && !stop_on_hot;
    wire next_stop = lvl[0] && stop_on_hot;
    wire next_shutdown = lvl[2] && sd_on_l3;
    wire next_ot_irq = DIE_ABOVE_LEVEL[1] && !lvl[1] && ot_irq_en;

    ////////////////////////////////////////////////////////////////////////
    // safe mode after charge timer expiry, left near target voltage
    wire next_safe = (safe_mode || CHG_TIMER_EXPIRED) && !BATT_NEAR_TARGET;

    // battery presence
    wire sense_changed = det_en && (BATTERY_SENSE_VOLTAGE_HI != present);

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            present <= 1'b0;
            safe_mode <= 1'b0;
            CHG_MIN_CURRENT <= 1'b0;
            CHG_STOP <= 1'b0;
            CHG_SAFE_MODE <= 1'b0;
            SHUTDOWN_REQ <= 1'b0;
            BATT_PRESENT_IRQ <= 1'b0;
            DIE_OVERTEMP_IRQ <= 1'b0;
        end
        else
        begin
            if (det_en)
                present <= BATTERY_SENSE_VOLTAGE_HI;
            safe_mode <= next_safe;
            CHG_MIN_CURRENT <= next_min_cur;
            CHG_STOP <= next_stop;
            CHG_SAFE_MODE <= next_safe;
            SHUTDOWN_REQ <= next_shutdown;
            BATT_PRESENT_IRQ <= sense_changed;
            DIE_OVERTEMP_IRQ <= next_ot_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator pattern selection
    wire alarm_hot = lvl[1];
    wire a_fast = VBUS_OVER_6V3;
    wire a_slow = safe_mode || alarm_hot;
    wire b_fast = VBUS_OVER_6V3 || safe_mode || alarm_hot;
    wire b_idle = !INPUT_PRESENT || !INPUT_SUFFICIENT;

    // alarms are tested before normal indication
    wire citc_pat_t pat_a = a_fast ? PAT_FOUR_HZ :
        a_slow ? PAT_ONE_HZ :
        CHARGING ? PAT_LOW : PAT_HIZ;
    wire citc_pat_t pat_b = b_fast ? PAT_FOUR_HZ :
        b_idle ? PAT_HIZ :
        BATT_FULL ? PAT_LOW :
        CHARGING ? PAT_ONE_HZ : PAT_HIZ;
    wire citc_pat_t pat_auto = ind_mode ? pat_b : pat_a;
    wire citc_pat_t pat_man = (man_pat == MAN_HALF_HZ) ? PAT_HALF_HZ :
        (man_pat == MAN_TWO_HZ) ? PAT_TWO_HZ :
        (man_pat == MAN_LOW) ? PAT_LOW : PAT_HIZ;
    wire citc_pat_t next_pat = ind_src ? pat_auto : pat_man;

    ////////////////////////////////////////////////////////////////////////
    // timebase: 1/16 s ticks, phase restarts on any pattern change
    wire tick = (presc == 23'(TICK_CYCLES - 1));
    wire pat_change = (next_pat != pat);

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pat <= PAT_HIZ;
            presc <= 23'h000000;
            phase <= 5'h00;
        end
        else if (pat_change)
        begin
            pat <= next_pat;
            presc <= 23'h000000;
            phase <= 5'h00;
        end
        else if (tick)
        begin
            presc <= 23'h000000;
            phase <= phase + 5'h01;
        end
        else
            presc <= presc + 23'h000001;
    end

    // low for the first quarter of each period
    logic low_now;
    always_comb
    begin
        case (pat)
            PAT_LOW: low_now = 1'b1;
            PAT_HALF_HZ: low_now = (phase[4:3] == 2'h0);
            PAT_ONE_HZ: low_now = (phase[3:2] == 2'h0);
            PAT_TWO_HZ: low_now = (phase[2:1] == 2'h0);
            PAT_FOUR_HZ: low_now = (phase[1:0] == 2'h0);
            default: low_now = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            CHARGE_INDICATOR_PIN_OUT <= 1'b0;
            CHARGE_INDICATOR_PIN_OE <= 1'b0;
        end
        else
        begin
            CHARGE_INDICATOR_PIN_OUT <= 1'b0;
            CHARGE_INDICATOR_PIN_OE <= low_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // battery probe, every 16 s while an input is present
    wire probe_due = tick && (probe_cnt == 8'(PROBE_TICKS - 1));

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            probe_cnt <= 8'h00;
            BATT_PROBE <= 1'b0;
        end
        else
        begin
            BATT_PROBE <= INPUT_PRESENT && probe_due;
            if (!INPUT_PRESENT)
                probe_cnt <= 8'h00;
            else if (tick)
                probe_cnt <= probe_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    wire pin_in_unused = CHARGE_INDICATOR_PIN_IN;

    a_manual_low: assert property (
        (!ind_src && man_pat == MAN_LOW) [*2] |=> CHARGE_INDICATOR_PIN_OE)
        else $error("manual low pattern not driving pin");
    a_manual_hiz: assert property (
        (!ind_src && man_pat == MAN_HIZ) [*2] |=> !CHARGE_INDICATOR_PIN_OE)
        else $error("manual hiz pattern drives pin");
    a_scheme_a_charge: assert property (
        (ind_src && !ind_mode && CHARGING && !a_fast && !a_slow) [*2]
        |=> CHARGE_INDICATOR_PIN_OE)
        else $error("scheme A charging not steady low");
    a_fast_duty: assert property (
        (pat == PAT_FOUR_HZ && phase[1:0] != 2'h0 && !pat_change)
        |=> !CHARGE_INDICATOR_PIN_OE)
        else $error("fast blink low outside first quarter");
    a_presence_irq: assert property (
        ($changed(present) && $past(det_en)) |-> BATT_PRESENT_IRQ)
        else $error("presence change without interrupt");
    a_status_present: assert property (
        (RD && ADDR == ADDR_POWER_STATUS)
        |=> RDATA[STAT_PRESENT_BIT] == $past(present))
        else $error("status bit 5 differs from presence");
    a_probe_pulse: assert property (
        BATT_PROBE |=> !BATT_PROBE [*2])
        else $error("probe pulse longer than one cycle");
    a_level1_stop: assert property (
        (lvl[0] && stop_on_hot) |=> CHG_STOP && !CHG_MIN_CURRENT)
        else $error("level one with stop bit did not stop");
    a_ot_irq_gate: assert property (
        DIE_OVERTEMP_IRQ |-> $past(ot_irq_en) && $rose(lvl[1]))
        else $error("over-temperature irq without enable");
    a_level3_shutdown: assert property (
        (lvl[2] && sd_on_l3) |=> SHUTDOWN_REQ)
        else $error("level three shutdown missing");

endmodule

//--- sim/citc_pack_led.sv
// battery pack and indicator led model for the charge indicator bench
`timescale 1ns/1ps
module citc_pack_led (
    // pin side
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level,
    // pack control from the bench
    input wire logic inserted,
    output logic sense_hi
);
    // led pulls the open-drain pin up when released
    assign pin_level = pin_oe ? pin_out : 1'b1;
    // pack above the presence threshold only while inserted
    assign sense_hi = inserted;
endmodule

//--- sim/tb.sv
// self-checking bench for the charge indicator and die thermal controller
`timescale 1ns/1ps
module tb
    import citc_pkg::*;
;
    localparam int TK = 4;
    localparam int LIMIT = 60000;
    logic SYS_CLK = 0, ARST_N = 0, WR = 0, RD = 0, rd_q = 0, ins = 0;
    logic [7:0] ADDR = 0, WDATA = 0, RDATA;
    logic INPUT_PRESENT = 1, INPUT_SUFFICIENT = 1, CHARGING = 0, BATT_FULL = 0;
    logic VBUS_OVER_6V3 = 0, CHG_TIMER_EXPIRED = 0, BATT_NEAR_TARGET = 0;
    logic [2:0] DIE_ABOVE_LEVEL = 0, DIE_BELOW_HYST = 3'h7;
    logic sense, pin_lvl, pin_out, OE, MIN, STOP, SAFE, SD, PROBE, BIRQ, OIRQ;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'd86623;
    int miscompares = 0, n_tests = 0, cycles = 0, n_birq = 0, n_oirq = 0, n_probe = 0;
    citc_pat_t man_map[4] = '{PAT_HIZ, PAT_HALF_HZ, PAT_TWO_HZ, PAT_LOW};
    logic [7:0] addr_t[5] = '{8'h32, 8'h34, 8'h35, 8'h43, 8'h8F};
    logic [7:0] mask_t[5] = '{8'h78, 8'hD3, 8'h08, 8'h80, 8'h04};
    logic [7:0] rst_t[5] = '{8'h40, 8'h41, 8'h00, 8'h00, 8'h00};

    always #5 SYS_CLK = ~SYS_CLK;

    citc_top #(.TICK_CYCLES(TK)) u_dut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INPUT_PRESENT(INPUT_PRESENT),
        .INPUT_SUFFICIENT(INPUT_SUFFICIENT), .CHARGING(CHARGING), .BATT_FULL(BATT_FULL),
        .VBUS_OVER_6V3(VBUS_OVER_6V3), .CHG_TIMER_EXPIRED(CHG_TIMER_EXPIRED),
        .BATT_NEAR_TARGET(BATT_NEAR_TARGET), .BATTERY_SENSE_VOLTAGE_HI(sense),
        .DIE_ABOVE_LEVEL(DIE_ABOVE_LEVEL), .DIE_BELOW_HYST(DIE_BELOW_HYST),
        .CHARGE_INDICATOR_PIN_IN(pin_lvl), .CHARGE_INDICATOR_PIN_OUT(pin_out),
        .CHARGE_INDICATOR_PIN_OE(OE), .CHG_MIN_CURRENT(MIN), .CHG_STOP(STOP),
        .CHG_SAFE_MODE(SAFE), .SHUTDOWN_REQ(SD), .BATT_PROBE(PROBE),
        .BATT_PRESENT_IRQ(BIRQ), .DIE_OVERTEMP_IRQ(OIRQ));

    citc_pack_led u_pack (.pin_out(pin_out), .pin_oe(OE), .pin_level(pin_lvl),
        .inserted(ins), .sense_hi(sense));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s exp %0h got %0h", nm, e, s);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    // note the expected data, the monitor compares it one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back(e);
        @(posedge SYS_CLK);
        RD <= 1'b0;
    endtask

    // read data monitor, pulse counters and hang guard
    always @(posedge SYS_CLK)
    begin
        rd_q <= RD;
        if (rd_q === 1'b1)
            chk("rdata", RDATA, exp_q.pop_front());
        n_birq += (BIRQ === 1'b1);
        n_oirq += (OIRQ === 1'b1);
        n_probe += (PROBE === 1'b1);
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (OE !== v && n < 1000)
        begin
            n++;
            @(posedge SYS_CLK);
        end
    endtask

    // static patterns checked once, blinks by one full low and high run
    task automatic show(input citc_pat_t p);
        int q, lo, hi;
        q = (p == PAT_HALF_HZ) ? 8 : (p == PAT_ONE_HZ) ? 4 : (p == PAT_TWO_HZ) ? 2 : 1;
        lo = 0;
        hi = 0;
        cyc(4);
        if (p == PAT_HIZ || p == PAT_LOW)
        begin
            chk("pin_oe", OE, p == PAT_LOW);
            chk("pin_level", pin_lvl, p != PAT_LOW);
        end
        else
        begin
            wait_oe(1'b1);
            wait_oe(1'b0);
            while (OE === 1'b0 && hi < 1000)
            begin
                hi++;
                @(posedge SYS_CLK);
            end
            while (OE === 1'b1 && lo < 1000)
            begin
                lo++;
                @(posedge SYS_CLK);
            end
            chk("hiz_run", hi, 3 * q * TK);
            chk("low_run", lo, q * TK);
        end
    endtask

    task automatic auto_case(input logic mb, inp, chg, full, vb, hot, input citc_pat_t p);
        wr(8'h34, mb ? 8'h51 : 8'h41);
        INPUT_PRESENT <= inp;
        INPUT_SUFFICIENT <= inp;
        CHARGING <= chg;
        BATT_FULL <= full;
        VBUS_OVER_6V3 <= vb;
        DIE_ABOVE_LEVEL <= hot ? 3'h3 : 3'h0;
        DIE_BELOW_HYST <= hot ? 3'h0 : 3'h7;
        show(p);
    endtask

    task automatic heat(input logic [2:0] above, input logic [2:0] below);
        DIE_ABOVE_LEVEL <= above;
        DIE_BELOW_HYST <= below;
        cyc(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(8);
        ARST_N <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(addr_t[i], rst_t[i]);
        rd(8'h01, 8'h00);
        rd(8'h77, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            wr(addr_t[i], seed[7:0]);
            rd(addr_t[i], seed[7:0] & mask_t[i]);
            wr(addr_t[i], rst_t[i]);
        end
        wr(8'h01, 8'hFF);
        wr(8'h77, 8'hFF);
        rd(8'h01, 8'h00);
        rd(8'h77, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            wr(8'h32, 8'h40 | 8'(p << 4));
            show(man_map[p]);
        end
        wr(8'h32, 8'h48);
        auto_case(0, 1, 0, 0, 0, 0, PAT_HIZ);
        auto_case(0, 1, 1, 0, 0, 0, PAT_LOW);
        auto_case(0, 1, 1, 0, 1, 0, PAT_FOUR_HZ);
        auto_case(0, 1, 1, 0, 0, 1, PAT_ONE_HZ);
        auto_case(1, 0, 0, 0, 0, 0, PAT_HIZ);
        auto_case(1, 1, 1, 0, 0, 0, PAT_ONE_HZ);
        auto_case(1, 1, 0, 1, 0, 0, PAT_LOW);
        auto_case(1, 1, 1, 0, 0, 1, PAT_FOUR_HZ);
        auto_case(1, 1, 1, 0, 1, 0, PAT_FOUR_HZ);
        CHG_TIMER_EXPIRED <= 1'b1;
        cyc(1);
        CHG_TIMER_EXPIRED <= 1'b0;
        VBUS_OVER_6V3 <= 1'b0;
        show(PAT_FOUR_HZ);
        auto_case(0, 1, 1, 0, 0, 0, PAT_ONE_HZ);
        rd(8'h01, 8'h08);
        chk("safe_mode", SAFE, 1);
        BATT_NEAR_TARGET <= 1'b1;
        cyc(2);
        BATT_NEAR_TARGET <= 1'b0;
        show(PAT_LOW);
        wr(8'h32, 8'h70);
        show(PAT_LOW);
        wr(8'h32, 8'h40);
        heat(3'h1, 3'h6);
        chk("min_cur", {MIN, STOP}, 2'b10);
        wr(8'h35, 8'h08);
        cyc(3);
        chk("stop", {MIN, STOP}, 2'b01);
        wr(8'h35, 8'h00);
        n_oirq = 0;
        heat(3'h3, 3'h4);
        rd(8'h01, 8'h80);
        chk("ot_irq_off", n_oirq, 0);
        heat(3'h0, 3'h0);
        rd(8'h01, 8'h80);
        chk("min_hold", MIN, 1);
        heat(3'h0, 3'h7);
        rd(8'h01, 8'h00);
        chk("resume", {MIN, STOP}, 2'b00);
        wr(8'h43, 8'h80);
        wr(8'h8F, 8'h04);
        heat(3'h3, 3'h0);
        chk("ot_irq", n_oirq, 1);
        chk("no_sd", SD, 0);
        heat(3'h7, 3'h0);
        chk("shutdown", SD, 1);
        // mid-run reset clears outputs and register fields
        ARST_N <= 1'b0;
        cyc(2);
        chk("reset_outs", {SD, MIN, STOP}, 3'h0);
        ARST_N <= 1'b1;
        rd(8'h43, 8'h00);
        rd(8'h8F, 8'h00);
        wr(8'h8F, 8'h04);
        cyc(3);
        chk("sd_again", SD, 1);
        heat(3'h0, 3'h7);
        chk("sd_clr", SD, 0);
        n_birq = 0;
        ins <= 1'b1;
        cyc(4);
        rd(8'h01, 8'h20);
        ins <= 1'b0;
        cyc(4);
        rd(8'h01, 8'h00);
        chk("batt_irq", n_birq, 2);
        wr(8'h32, 8'h00);
        ins <= 1'b1;
        cyc(4);
        rd(8'h01, 8'h00);
        chk("det_off", n_birq, 2);
        INPUT_PRESENT <= 1'b0;
        cyc(4);
        n_probe = 0;
        cyc(2100);
        chk("no_probe", n_probe, 0);
        INPUT_PRESENT <= 1'b1;
        n_probe = 0;
        cyc(2100);
        chk("probe", n_probe, 2);
        final_report();
    end
endmodule
